// ===== design/dpram_port_host.sv
`timescale 1ns/1ps
module dpram_port_host
  import dpram_host_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_data_out,
  output logic                   mem_data_oe,
  input  wire logic [DATA_W-1:0] mem_data_in,
  output logic                   chip_select_n,
  output logic                   upper_byte_enable_n,
  output logic                   lower_byte_enable_n,
  output logic                   write_strobe_n,
  output logic                   output_enable_n,
  output logic                   flag_select_n,
  input  wire logic              busy_n_in
);

  // ------------------------------------------------------------
  // types and state
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_PULSE, ST_BLOCKED, ST_HOLD,
    ST_WEND, ST_READ, ST_RELEASE, ST_GAP
  } state_type;

  state_type         state_ff,    nxt_state;
  logic [1:0]        op_ff,       nxt_op;
  logic              oe_low_ff,   nxt_oe_low;
  logic [ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;
  logic [DATA_W-1:0] data_out_ff, nxt_data_out;
  logic              data_oe_ff,  nxt_data_oe;
  logic              cs_n_ff,     nxt_cs_n;
  logic              ub_n_ff,     nxt_ub_n;
  logic              lb_n_ff,     nxt_lb_n;
  logic              rw_n_ff,     nxt_rw_n;
  logic              oe_n_ff,     nxt_oe_n;
  logic              flag_n_ff,   nxt_flag_n;
  logic [DATA_W-1:0] rdata_ff,    nxt_rdata;

  logic [ADDR_W-1:0] addr_reg_ff,  nxt_addr_reg;
  logic [DATA_W-1:0] wdata_reg_ff, nxt_wdata_reg;
  logic              done_ff,      nxt_done;
  logic              bseen_ff,     nxt_bseen;
  logic [31:0]       reg_rdata_ff, nxt_reg_rdata;

  logic              set_done;
  logic [CNT_W-1:0]  cnt;
  logic              busy_s;
  logic [DATA_W-1:0] data_s;
  logic              is_write;
  logic [7:0]        pulse_last;

  // ------------------------------------------------------------
  // pin input synchronisers and state timer
  // ------------------------------------------------------------
  // busy pin idles high: reset the stages high so status shows no busy
  sync2 #(.W(1), .RST_VAL(1'b1)) u_busy_sync (
    .clk   (clk),
    .reset (reset),
    .d     (busy_n_in),
    .q     (busy_s)
  );

  sync2 #(.W(DATA_W)) u_data_sync (
    .clk   (clk),
    .reset (reset),
    .d     (mem_data_in),
    .q     (data_s)
  );

  cycle_counter u_timer (
    .clk   (clk),
    .reset (reset),
    .clear (nxt_state != state_ff),
    .count (cnt)
  );

  assign is_write   = (op_ff == OP_ARRAY_WR) || (op_ff == OP_FLAG_WR);
  assign pulse_last = oe_low_ff ? PULSE_LAST_OE_LOW : PULSE_LAST_OE_HIGH;

  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  always_comb begin
    nxt_state    = state_ff;
    nxt_op       = op_ff;
    nxt_oe_low   = oe_low_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_data_out = data_out_ff;
    nxt_data_oe  = data_oe_ff;
    nxt_cs_n     = cs_n_ff;
    nxt_ub_n     = ub_n_ff;
    nxt_lb_n     = lb_n_ff;
    nxt_rw_n     = rw_n_ff;
    nxt_oe_n     = oe_n_ff;
    nxt_flag_n   = flag_n_ff;
    nxt_rdata    = rdata_ff;
    set_done     = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (reg_wr && (reg_addr == REG_CMD)) begin
          nxt_op       = reg_wdata[CMD_OP_LSB +: 2];
          nxt_oe_low   = reg_wdata[CMD_OE_LOW_BIT];
          nxt_mem_addr = addr_reg_ff;
          nxt_state    = ST_SETUP;
          if (reg_wdata[CMD_OP_LSB + 1]) begin
            // flag access: array deselected, all bytes off
            nxt_flag_n = 1'b0;
            nxt_cs_n   = 1'b1;
            nxt_ub_n   = 1'b1;
            nxt_lb_n   = 1'b1;
          end else begin
            nxt_cs_n   = 1'b0;
            nxt_ub_n   = ~reg_wdata[CMD_UPPER_BIT];
            nxt_lb_n   = ~reg_wdata[CMD_LOWER_BIT];
          end
          nxt_oe_n = reg_wdata[CMD_OP_LSB] ? 1'b0 : ~reg_wdata[CMD_OE_LOW_BIT];
        end
      end
      ST_SETUP: begin
        if (cnt >= APS_LAST) begin
          if (is_write) begin
            nxt_rw_n     = 1'b0;
            nxt_data_out = wdata_reg_ff;
            nxt_data_oe  = ~oe_low_ff;
            nxt_state    = ST_PULSE;
          end else begin
            nxt_state = ST_READ;
          end
        end
      end
      ST_PULSE: begin
        if (!busy_s) begin
          nxt_state = ST_BLOCKED;
        end else begin
          if (cnt >= WZ_CYC) begin
            nxt_data_oe = 1'b1;
          end
          if (cnt >= pulse_last) begin
            nxt_rw_n  = 1'b1;
            nxt_oe_n  = 1'b1;
            nxt_state = ST_WEND;
          end
        end
      end
      ST_BLOCKED: begin
        if (busy_s) begin
          nxt_data_oe = 1'b1;
          nxt_state   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt >= WH_LAST) begin
          nxt_rw_n  = 1'b1;
          nxt_oe_n  = 1'b1;
          nxt_state = ST_WEND;
        end
      end
      ST_WEND: begin
        // data still driven for one cycle after the strobe rises
        nxt_data_oe = 1'b0;
        nxt_cs_n    = 1'b1;
        nxt_flag_n  = 1'b1;
        nxt_ub_n    = 1'b1;
        nxt_lb_n    = 1'b1;
        nxt_state   = ST_RELEASE;
      end
      ST_READ: begin
        if (cnt >= READ_LAST) begin
          nxt_rdata  = data_s;
          nxt_cs_n   = 1'b1;
          nxt_flag_n = 1'b1;
          nxt_ub_n   = 1'b1;
          nxt_lb_n   = 1'b1;
          nxt_oe_n   = 1'b1;
          nxt_state  = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (op_ff == OP_FLAG_WR) begin
          nxt_state = ST_GAP;
        end else begin
          set_done  = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_GAP: begin
        if (cnt >= GAP_LAST) begin
          set_done  = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff    <= ST_IDLE;
      op_ff       <= OP_ARRAY_WR;
      oe_low_ff   <= 1'b0;
      mem_addr_ff <= ADDR_RESET;
      data_out_ff <= DATA_RESET;
      data_oe_ff  <= 1'b0;
      cs_n_ff     <= 1'b1;
      ub_n_ff     <= 1'b1;
      lb_n_ff     <= 1'b1;
      rw_n_ff     <= 1'b1;
      oe_n_ff     <= 1'b1;
      flag_n_ff   <= 1'b1;
      rdata_ff    <= DATA_RESET;
    end else begin
      state_ff    <= nxt_state;
      op_ff       <= nxt_op;
      oe_low_ff   <= nxt_oe_low;
      mem_addr_ff <= nxt_mem_addr;
      data_out_ff <= nxt_data_out;
      data_oe_ff  <= nxt_data_oe;
      cs_n_ff     <= nxt_cs_n;
      ub_n_ff     <= nxt_ub_n;
      lb_n_ff     <= nxt_lb_n;
      rw_n_ff     <= nxt_rw_n;
      oe_n_ff     <= nxt_oe_n;
      flag_n_ff   <= nxt_flag_n;
      rdata_ff    <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_comb begin
    nxt_addr_reg  = addr_reg_ff;
    nxt_wdata_reg = wdata_reg_ff;
    nxt_reg_rdata = reg_rdata_ff;
    if (reg_wr && (reg_addr == REG_ADDR)) begin
      nxt_addr_reg = reg_wdata[ADDR_W-1:0];
    end
    if (reg_wr && (reg_addr == REG_WDATA)) begin
      nxt_wdata_reg = reg_wdata[DATA_W-1:0];
    end
    // set wins over a write-one clear in the same cycle
    nxt_done  = set_done | (done_ff &
                ~(reg_wr && (reg_addr == REG_STATUS) && reg_wdata[STS_DONE_BIT]));
    nxt_bseen = (state_ff == ST_BLOCKED) | (bseen_ff &
                ~(reg_wr && (reg_addr == REG_STATUS) && reg_wdata[STS_BSEEN_BIT]));
    if (reg_rd) begin
      case (reg_addr)
        REG_ADDR:   nxt_reg_rdata = {19'h0_0000, addr_reg_ff};
        REG_WDATA:  nxt_reg_rdata = {16'h0000, wdata_reg_ff};
        REG_STATUS: nxt_reg_rdata = {28'h000_0000, ~busy_s, bseen_ff, done_ff,
                                     state_ff != ST_IDLE};
        REG_RDATA:  nxt_reg_rdata = {16'h0000, rdata_ff};
        default:    nxt_reg_rdata = RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg_ff  <= ADDR_RESET;
      wdata_reg_ff <= DATA_RESET;
      done_ff      <= 1'b0;
      bseen_ff     <= 1'b0;
      reg_rdata_ff <= RDATA_RESET;
    end else begin
      addr_reg_ff  <= nxt_addr_reg;
      wdata_reg_ff <= nxt_wdata_reg;
      done_ff      <= nxt_done;
      bseen_ff     <= nxt_bseen;
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  assign reg_rdata           = reg_rdata_ff;
  assign mem_addr            = mem_addr_ff;
  assign mem_data_out        = data_out_ff;
  assign mem_data_oe         = data_oe_ff;
  assign chip_select_n       = cs_n_ff;
  assign upper_byte_enable_n = ub_n_ff;
  assign lower_byte_enable_n = lb_n_ff;
  assign write_strobe_n      = rw_n_ff;
  assign output_enable_n     = oe_n_ff;
  assign flag_select_n       = flag_n_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sel_hold_a: assert property (@(posedge clk) disable iff (reset)
    !rw_n_ff && !$past(rw_n_ff) |-> $stable(cs_n_ff) && $stable(flag_n_ff))
    else $error("selection changed during write");

  addr_guard_a: assert property (@(posedge clk) disable iff (reset)
    $changed(mem_addr_ff) |-> rw_n_ff)
    else $error("address changed with write strobe low");

  no_fight_a: assert property (@(posedge clk) disable iff (reset)
    data_oe_ff && !oe_n_ff |-> !rw_n_ff && !$past(rw_n_ff, 2))
    else $error("data driven while device may drive");

  pulse_high_a: assert property (@(posedge clk) disable iff (reset)
    $rose(rw_n_ff) && !oe_low_ff |-> !$past(rw_n_ff, 3))
    else $error("write pulse too short");

  pulse_oelow_a: assert property (@(posedge clk) disable iff (reset)
    $rose(rw_n_ff) && oe_low_ff |-> !$past(rw_n_ff, 5))
    else $error("write pulse too short with output enable low");

  flag_gap_a: assert property (@(posedge clk) disable iff (reset)
    $rose(flag_n_ff) && (op_ff == OP_FLAG_WR) |=> flag_n_ff && (state_ff == ST_GAP))
    else $error("flag write to read gap missing");

  arb_setup_a: assert property (@(posedge clk) disable iff (reset)
    $fell(rw_n_ff) |-> (!$past(cs_n_ff) || !$past(flag_n_ff)) && $stable(mem_addr_ff))
    else $error("write began without address lead");

  busy_hold_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == ST_BLOCKED) && busy_s |=> !rw_n_ff [*3])
    else $error("write not held after busy release");

  busy_start_a: assert property (@(posedge clk) disable iff (reset)
    (state_ff == ST_PULSE) && !busy_s |=> (state_ff == ST_BLOCKED) && !rw_n_ff)
    else $error("busy at write did not block");

  data_hold_a: assert property (@(posedge clk) disable iff (reset)
    $rose(rw_n_ff) |-> data_oe_ff && $stable(data_out_ff))
    else $error("write data not held past end of write");

endmodule : dpram_port_host

// ===== pkg/dpram_host_pkg.sv
package dpram_host_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W      = 13;
  localparam int DATA_W      = 16;
  localparam int CNT_W       = 8;
  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // timing in ns and derived cycle counts (200 MHz)
  // ------------------------------------------------------------
  localparam int CLK_NS    = 5;
  localparam int T_WP_NS   = 12;
  localparam int T_DW_NS   = 10;
  localparam int T_WZ_NS   = 10;
  localparam int T_SWRD_NS = 5;
  localparam int T_APS_NS  = 5;
  localparam int T_WH_NS   = 12;
  localparam int T_AA_NS   = 15;

  localparam logic [7:0] WP_CYC   = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] DW_CYC   = 8'((T_DW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WZ_CYC   = 8'((T_WZ_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SWRD_CYC = 8'((T_SWRD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] APS_CYC  = 8'((T_APS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WH_CYC   = 8'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] AA_CYC   = 8'((T_AA_NS + CLK_NS - 1) / CLK_NS);

  localparam logic [7:0] PULSE_LAST_OE_HIGH = WP_CYC - 8'h01;
  localparam logic [7:0] PULSE_LAST_OE_LOW  = WZ_CYC + DW_CYC;
  localparam logic [7:0] APS_LAST           = APS_CYC - 8'h01;
  localparam logic [7:0] WH_LAST            = WH_CYC - 8'h01;
  localparam logic [7:0] GAP_LAST           = SWRD_CYC - 8'h01;
  localparam logic [7:0] READ_LAST          = AA_CYC + 8'(SYNC_STAGES);

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_OE_LOW_BIT = 2;
  localparam int CMD_UPPER_BIT  = 3;
  localparam int CMD_LOWER_BIT  = 4;

  localparam int STS_RUN_BIT   = 0;
  localparam int STS_DONE_BIT  = 1;
  localparam int STS_BSEEN_BIT = 2;
  localparam int STS_BUSY_BIT  = 3;

  localparam logic [1:0] OP_ARRAY_WR = 2'h0;
  localparam logic [1:0] OP_ARRAY_RD = 2'h1;
  localparam logic [1:0] OP_FLAG_WR  = 2'h2;
  localparam logic [1:0] OP_FLAG_RD  = 2'h3;

  localparam logic [ADDR_W-1:0] ADDR_RESET  = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;
  localparam logic [31:0]       RDATA_RESET = 32'h0000_0000;

endpackage : dpram_host_pkg

// ===== design/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int           W       = 1,
  // reset level equals the pin's idle level, so no false event follows reset
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : sync2

// ===== design/cycle_counter.sv
`timescale 1ns/1ps
module cycle_counter
  import dpram_host_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clear,
  output logic      [CNT_W-1:0] count
);

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;

  // saturating up-counter, restarted on every state change
  always_comb begin
    nxt_count = count_ff;
    if (clear) begin
      nxt_count = '0;
    end else if (count_ff != '1) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

endmodule : cycle_counter

// ===== dv/dpram_port_model.sv
`timescale 1ns/1ps
module dpram_port_model
  import dpram_host_pkg::*;
#(
  parameter int LAG_NS = 0
) (
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] pins,
  input  wire logic              chip_select_n,
  input  wire logic              upper_byte_enable_n,
  input  wire logic              lower_byte_enable_n,
  input  wire logic              write_strobe_n,
  input  wire logic              output_enable_n,
  input  wire logic              flag_select_n,
  input  wire logic              hold_busy,
  output logic      [DATA_W-1:0] drive_data,
  output logic                   drives,
  output logic                   busy_n
);
  // ----------------------------------------
  // storage and selection
  // ----------------------------------------
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0]        sem_ff;
  logic [DATA_W-1:0] last_ff;
  logic [DATA_W-1:0] rd_val;
  logic              arr_sel;
  logic              flag_sel;

  initial begin
    sem_ff  = 8'hFF;
    last_ff = 16'h0000;
  end

  assign arr_sel  = !chip_select_n && !(upper_byte_enable_n && lower_byte_enable_n);
  assign flag_sel = !flag_select_n && !arr_sel;
  assign drives   = !output_enable_n && write_strobe_n && (arr_sel || flag_sel);
  assign rd_val   = arr_sel ? mem[addr] : {DATA_W{sem_ff[addr[2:0]]}};
  // released pins show the inverse of the last value
  assign #(LAG_NS) drive_data = drives ? rd_val : ~last_ff;
  assign busy_n   = !hold_busy;

  // ----------------------------------------
  // writes, gated while busy is in force
  // ----------------------------------------
  always @(posedge clk) begin
    if (!write_strobe_n && !hold_busy) begin
      if (arr_sel && !upper_byte_enable_n)
        mem[addr][15:8] <= pins[15:8];
      if (arr_sel && !lower_byte_enable_n)
        mem[addr][7:0] <= pins[7:0];
      if (flag_sel)
        sem_ff[addr[2:0]] <= pins[0];
    end
    if (drives)
      last_ff <= rd_val;
  end
endmodule : dpram_port_model

// ===== dv/dpram_port_host_tb.sv
`timescale 1ns/1ps
module dpram_port_host_tb;
  import dpram_host_pkg::*;
  localparam int WP_MIN   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WZDW_MIN = (T_WZ_NS + T_DW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WH_MIN   = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_MIN  = (T_SWRD_NS + CLK_NS - 1) / CLK_NS;

  logic              clk, reset, reg_wr, reg_rd, hold_busy, drives, busy_n_in;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, s;
  logic [ADDR_W-1:0] mem_addr, prev_addr;
  logic [DATA_W-1:0] mem_data_out, mem_data_in, drive_data;
  logic              mem_data_oe, chip_select_n, upper_byte_enable_n, lower_byte_enable_n;
  logic              write_strobe_n, output_enable_n, flag_select_n, prev_wsn, prev_oen;
  int                n_fail, total_checks, low_cnt, rel_cnt, since_fw;
  logic              oe_seen, blk;

  assign mem_data_in = mem_data_oe ? mem_data_out : drive_data;

  dpram_port_host DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in),
    .chip_select_n(chip_select_n), .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .flag_select_n(flag_select_n), .busy_n_in(busy_n_in));

  dpram_port_model #(.LAG_NS(12)) ram (.clk(clk), .addr(mem_addr), .pins(mem_data_in),
    .chip_select_n(chip_select_n), .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .flag_select_n(flag_select_n),
    .hold_busy(hold_busy), .drive_data(drive_data), .drives(drives), .busy_n(busy_n_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_read(a, d);
    check(what, d, exp);
  endtask : rd_check

  task automatic wait_done(input logic [31:0] exp);
    logic [31:0] d;
    int          n;
    d = 32'h0;
    n = 0;
    while (d[STS_DONE_BIT] !== 1'b1 && n < 100) begin
      reg_read(REG_STATUS, d);
      n++;
    end
    check("status", d, exp);
    reg_write(REG_STATUS, 32'h0000_0006);
  endtask : wait_done

  // ctl is {lower, upper, output enable low}
  task automatic run_op(input logic [1:0] op, input logic [2:0] ctl,
                        input logic [ADDR_W-1:0] a, input logic [15:0] d,
                        input logic [31:0] exp);
    reg_write(REG_ADDR, {19'h0, a});
    reg_write(REG_WDATA, {16'h0, d});
    reg_write(REG_CMD, {27'h0, ctl, op});
    wait_done(exp);
  endtask : run_op

  // ----------------------------------------
  // pin monitor
  // ----------------------------------------
  always @(posedge clk) begin
    since_fw++;
    if (!reset) begin
      if (!write_strobe_n && !prev_wsn)
        check("addr_hold", 32'(mem_addr), 32'(prev_addr));
      if (mem_data_oe && drives)
        check("bus_fight", 1, 0);
      if (!chip_select_n && !flag_select_n)
        check("sel_both", 1, 0);
      if (!output_enable_n && prev_oen && !flag_select_n)
        check("flag_gap", 32'(since_fw >= GAP_MIN), 1);
      if (!write_strobe_n) begin
        low_cnt++;
        oe_seen |= !output_enable_n;
        blk |= !busy_n_in;
        if (busy_n_in)
          rel_cnt++;
      end
      if (write_strobe_n && !prev_wsn) begin
        check("pulse_len", 32'(low_cnt >= (oe_seen ? WZDW_MIN : WP_MIN)), 1);
        check("data_hold", 32'(mem_data_oe), 1);
        if (blk)
          check("hold_after", 32'(rel_cnt >= WH_MIN), 1);
        if (!flag_select_n)
          since_fw = 0;
        low_cnt = 0;
        rel_cnt = 0;
        oe_seen = 1'b0;
        blk = 1'b0;
      end
    end
    prev_wsn  = write_strobe_n;
    prev_oen  = output_enable_n;
    prev_addr = mem_addr;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    #1 check("pins_idle", {25'h0, chip_select_n, upper_byte_enable_n, lower_byte_enable_n,
      write_strobe_n, output_enable_n, flag_select_n, mem_data_oe}, 32'h7E);
    rd_check("status0", REG_STATUS, 32'h0);
    rd_check("unmapped", 8'h14, 32'h0);
  endtask : t_reset

  task automatic t_array();
    run_op(OP_ARRAY_WR, 3'h6, 13'h0155, 16'hA5C3, 32'h2);
    check("mem_full", {16'h0, ram.mem[13'h0155]}, 32'hA5C3);
    run_op(OP_ARRAY_WR, 3'h3, 13'h0155, 16'h12FF, 32'h2);
    check("mem_upper", {16'h0, ram.mem[13'h0155]}, 32'h12C3);
    run_op(OP_ARRAY_WR, 3'h4, 13'h1FFF, 16'h5A3C, 32'h2);
    check("mem_lower", {24'h0, ram.mem[13'h1FFF][7:0]}, 32'h3C);
    run_op(OP_ARRAY_RD, 3'h6, 13'h0155, 16'h0000, 32'h2);
    rd_check("rd_back", REG_RDATA, 32'h12C3);
  endtask : t_array

  task automatic t_flag();
    for (int v = 0; v < 2; v++) begin
      run_op(OP_FLAG_WR, 3'h0, 13'h0003, 16'(v), 32'h2);
      run_op(OP_FLAG_RD, 3'h0, 13'h0003, 16'h0000, 32'h2);
      rd_check("flag_rd", REG_RDATA, v ? 32'hFFFF : 32'h0);
    end
    run_op(OP_FLAG_WR, 3'h0, 13'h0004, 16'h0000, 32'h2);
    run_op(OP_FLAG_RD, 3'h0, 13'h0003, 16'h0000, 32'h2);
    rd_check("flag_other", REG_RDATA, 32'hFFFF);
  endtask : t_flag

  task automatic t_busy();
    run_op(OP_ARRAY_WR, 3'h6, 13'h0200, 16'h0000, 32'h2);
    hold_busy <= 1'b1;
    repeat (4) @(posedge clk);
    reg_write(REG_WDATA, 32'h0000_BEEF);
    reg_write(REG_CMD, 32'h0000_0018);
    repeat (20) @(posedge clk);
    check("blocked", {16'h0, ram.mem[13'h0200]}, 32'h0);
    reg_read(REG_STATUS, s);
    check("run_busy", s & 32'h9, 32'h9);
    // a second command while running must be ignored
    reg_write(REG_CMD, 32'h0000_0019);
    hold_busy <= 1'b0;
    wait_done(32'h6);
    check("mem_late", {16'h0, ram.mem[13'h0200]}, 32'hBEEF);
    rd_check("refused", REG_RDATA, 32'hFFFF);
  endtask : t_busy

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("BAD watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    hold_busy = 1'b0;
    n_fail = 0;
    total_checks = 0;
    low_cnt = 0;
    rel_cnt = 0;
    since_fw = 100;
    oe_seen = 1'b0;
    blk = 1'b0;
    prev_wsn = 1'b1;
    prev_oen = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_array();
    t_flag();
    t_busy();
    close_out();
  end
endmodule : dpram_port_host_tb
